//--- key_irq_map.svh
// register offsets, field positions and reset values of the pin-change interrupt unit
`ifndef KEY_IRQ_MAP_SVH
`define KEY_IRQ_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses, 16-bit address space)
// ----------------------------------------------------------------------------
`define KEY_STATUS_CONTROL_OFFSET 16'h003C
`define KEY_PIN_ENABLE_OFFSET     16'h307C
`define KEY_POLARITY_SELECT_OFFSET 16'h307D
`define KEY_IRQ_STATUS_OFFSET     16'h3080
`define KEY_IRQ_MASK_OFFSET       16'h3081

// ----------------------------------------------------------------------------
// status/control field positions
// ----------------------------------------------------------------------------
`define LEVEL_SENSE_SELECT_BIT 0
`define IRQ_ENABLE_BIT_POS     1
`define FLAG_ACKNOWLEDGE_BIT   2
`define EVENT_FLAG_BIT         3

// ----------------------------------------------------------------------------
// event status bits of the interrupt block
// ----------------------------------------------------------------------------
`define EVT_EDGE_BIT  0
`define EVT_LEVEL_BIT 1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define KEY_STATUS_CONTROL_RESET  8'h00
`define KEY_PIN_ENABLE_RESET      8'h00
`define KEY_POLARITY_SELECT_RESET 8'h00
`define KEY_IRQ_MASK_RESET        8'h00

`endif

//--- key_irq_pkg.sv
// types shared by the pin-change interrupt unit
`default_nettype none
package key_irq_pkg;

  // edge detector arming state
  typedef enum logic [0:0] {
    ARM_WAIT_IDLE = 1'b0, // waiting until every enabled pin is deasserted
    ARM_READY     = 1'b1  // a first/new edge may be recognised
  } arm_state_t;

endpackage : key_irq_pkg
`default_nettype wire

//--- key_switch_model.sv
// switch matrix model that drives the wake input pins
`timescale 1ns/1ps
`default_nettype none

module key_switch_model (
  input  wire logic       core_clk,      // bus clock, pins move right after its edge
  output logic      [7:0] wake_input_pin // pin levels seen by the block
);
  // ----------------------------------------------------------------------
  // pin driver
  // ----------------------------------------------------------------------
  // pull-ups hold idle pins high until a switch closes
  initial wake_input_pin = 8'hFF;

  // a pattern lands just after a rising edge and stays until the next call,
  // so the synchroniser never sees a level shorter than one bus cycle
  task automatic drive(input logic [7:0] v);
    @(posedge core_clk);
    wake_input_pin <= v;
  endtask : drive
endmodule : key_switch_model

`default_nettype wire

//--- keyboard_pin_interrupt.sv
// pin-change interrupt unit: up to eight pins, polarity, edge or edge+level detection
//
// Functional notes
// - per-pin enable; disabled pins never count
// - polarity bit: 0 falling/low, 1 rising/high
// - mode bit 0: edge-only or edge+level
// - event flag bit 3, writes ignored
// - writing one to bit 2 requests clear
// - irq when enable bit and flag set
// - bits 7..4 read zero, ignore writes
// - falling edge: high then low sample
// - rising edge: low then high sample
// - first edge needs all pins deasserted
// - re-arm only after all pins deasserted
// - edge mode: valid edge sets flag
// - level mode: edge or level sets flag
// - level mode: clear only when all deasserted
// - pin event wakes processor when enabled
// - stop mode: asynchronous pin detection (this block samples pins on core_clk only)
// - debug mode: operate normally
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "key_irq_map.svh"

module keyboard_pin_interrupt #(
  parameter int PIN_COUNT = 8 // number of wake input pins, at most eight
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic [15:0]          addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr_stb,
  input  wire logic                 rd_stb,
  output logic      [7:0]           rdata,
  input  wire logic [PIN_COUNT-1:0] wake_input_pin,
  input  wire logic                 stop_mode,
  output logic                      irq_request,
  output logic                      wake_request,
  output logic                      irq
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------

  // turn raw pin levels into "asserted" bits for the selected polarity
  function automatic logic [PIN_COUNT-1:0] asserted_of(
    input logic [PIN_COUNT-1:0] lvl,
    input logic [PIN_COUNT-1:0] pol
  );
    asserted_of = ~(lvl ^ pol);
  endfunction : asserted_of

  // address match on a full 16-bit compare
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction : hit

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic                 level_sense_select; // detection mode
  logic                 irq_enable_bit;     // request gate
  logic                 event_flag;         // sticky detected flag
  logic [PIN_COUNT-1:0] pin_enable_bits;    // per-pin enable
  logic [PIN_COUNT-1:0] polarity_bits;      // per-pin sense
  logic [1:0]           evt_status;         // sticky event status
  logic [1:0]           evt_mask;           // mask for irq output

  // reset images of the byte-wide registers; fields are picked out of
  // them so a changed reset value in the map reaches every flop
  localparam logic [7:0] SC_RESET_VALUE   = `KEY_STATUS_CONTROL_RESET;  // status/control
  localparam logic [7:0] PE_RESET_VALUE   = `KEY_PIN_ENABLE_RESET;      // pin enables
  localparam logic [7:0] POL_RESET_VALUE  = `KEY_POLARITY_SELECT_RESET; // polarity select
  localparam logic [7:0] MASK_RESET_VALUE = `KEY_IRQ_MASK_RESET;        // event mask

  // synchroniser and detector state
  logic [PIN_COUNT-1:0] sync_a;      // first stage, read only by sync_b
  logic [PIN_COUNT-1:0] sync_b;      // second stage
  logic [PIN_COUNT-1:0] prev_b;      // previous sample for edge compare
  key_irq_pkg::arm_state_t arm_state; // detector arming
  key_irq_pkg::arm_state_t next_arm_state;

  // decoded strobes; the address compare is full width so mirror
  // addresses never alias onto a register
  logic wr_sc;
  logic wr_pe;
  logic wr_es;
  logic wr_st;
  logic wr_mk;
  logic ack_req;

  assign wr_sc   = wr_stb && hit(addr, `KEY_STATUS_CONTROL_OFFSET);
  assign wr_pe   = wr_stb && hit(addr, `KEY_PIN_ENABLE_OFFSET);
  assign wr_es   = wr_stb && hit(addr, `KEY_POLARITY_SELECT_OFFSET);
  assign wr_st   = wr_stb && hit(addr, `KEY_IRQ_STATUS_OFFSET);
  assign wr_mk   = wr_stb && hit(addr, `KEY_IRQ_MASK_OFFSET);
  // acknowledge is a write strobe only, never stored
  assign ack_req = wr_sc && wdata[`FLAG_ACKNOWLEDGE_BIT];

  // --------------------------------------------------------------------------
  // detection
  // --------------------------------------------------------------------------
  logic [PIN_COUNT-1:0] asserted_now;  // enabled pins asserted in this sample
  logic [PIN_COUNT-1:0] asserted_prev; // enabled pins asserted one cycle before
  logic                 any_asserted;
  logic                 edge_seen;
  logic                 level_seen;
  logic                 set_flag;

  // disabled pins are masked here so they can never contribute
  assign asserted_now  = asserted_of(sync_b, polarity_bits) & pin_enable_bits;
  assign asserted_prev = asserted_of(prev_b, polarity_bits) & pin_enable_bits;
  assign any_asserted  = |asserted_now;
  // deasserted then asserted on consecutive bus cycles, while armed
  assign edge_seen  = (arm_state == key_irq_pkg::ARM_READY) &&
                      (|(asserted_now & ~asserted_prev));
  assign level_seen = level_sense_select && any_asserted;
  assign set_flag   = edge_seen || level_seen;

  // two-stage synchroniser, then one more stage for the edge compare;
  // the stages reset low although idle pins usually sit high, which is
  // harmless: every pin enable resets to zero and the detector starts
  // disarmed, so the first real samples can never count as an edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
      prev_b <= '0;
    end else begin
      sync_a <= wake_input_pin;
      sync_b <= sync_a;
      prev_b <= sync_b;
    end
  end

  // arming: an edge disarms; re-arms only once every enabled pin is idle.
  // limitation: a pin enabled while already asserted gives no edge,
  // because enable and polarity mask both samples alike; software must
  // acknowledge after enabling pins, as the bring-up order asks
  always_comb begin
    next_arm_state = arm_state;
    case (arm_state)
      key_irq_pkg::ARM_WAIT_IDLE: begin
        if (!any_asserted) begin
          next_arm_state = key_irq_pkg::ARM_READY;
        end
      end
      key_irq_pkg::ARM_READY: begin
        if (edge_seen) begin
          next_arm_state = key_irq_pkg::ARM_WAIT_IDLE;
        end
      end
      default: next_arm_state = key_irq_pkg::ARM_WAIT_IDLE;
    endcase
  end

  // reset starts disarmed so a pin already asserted gives no edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arm_state <= key_irq_pkg::ARM_WAIT_IDLE;
    end else begin
      arm_state <= next_arm_state;
    end
  end

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------

  // mode and enable bits; upper bits are not stored so they read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level_sense_select <= SC_RESET_VALUE[`LEVEL_SENSE_SELECT_BIT];
      irq_enable_bit     <= SC_RESET_VALUE[`IRQ_ENABLE_BIT_POS];
    end else if (wr_sc) begin
      level_sense_select <= wdata[`LEVEL_SENSE_SELECT_BIT];
      irq_enable_bit     <= wdata[`IRQ_ENABLE_BIT_POS];
    end
  end

  // pin enables and polarity select
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_enable_bits <= PE_RESET_VALUE[PIN_COUNT-1:0];
      polarity_bits   <= POL_RESET_VALUE[PIN_COUNT-1:0];
    end else begin
      if (wr_pe) begin
        pin_enable_bits <= wdata[PIN_COUNT-1:0];
      end
      if (wr_es) begin
        polarity_bits <= wdata[PIN_COUNT-1:0];
      end
    end
  end

  // event flag: set wins over acknowledge; in level mode an asserted pin
  // holds it (level_seen is then a set anyway), writes to bit 3 do nothing.
  // the clear looks at the mode bit as it stood before the same write, so
  // a write that changes mode and acknowledges at once uses the old mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      event_flag <= SC_RESET_VALUE[`EVENT_FLAG_BIT];
    end else if (set_flag) begin
      event_flag <= 1'b1;
    end else if (ack_req && !(level_sense_select && any_asserted)) begin
      event_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // interrupt block: sticky status, write one to clear, mask
  // --------------------------------------------------------------------------
  // these bits feed only the shared irq line and the status read; they never touch the event
  // flag, so software that uses the flag alone sees no difference
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evt_status <= 2'h0;
      evt_mask   <= MASK_RESET_VALUE[1:0];
    end else begin
      // set beats write-one-to-clear in the same cycle
      evt_status[`EVT_EDGE_BIT] <= edge_seen ||
        (evt_status[`EVT_EDGE_BIT] && !(wr_st && wdata[`EVT_EDGE_BIT]));
      evt_status[`EVT_LEVEL_BIT] <= level_seen ||
        (evt_status[`EVT_LEVEL_BIT] && !(wr_st && wdata[`EVT_LEVEL_BIT]));
      if (wr_mk) begin
        evt_mask <= wdata[1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // outputs, all registered
  // --------------------------------------------------------------------------
  // request follows the flag one cycle later; the same path serves wait,
  // stop and debug modes since the request path never looks at stop_mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_request  <= 1'b0;
      irq          <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      irq_request <= event_flag && irq_enable_bit;
      irq         <= |(evt_status & evt_mask);
      // wake path: the bus clock may be stopped in stop mode; this flop flags a pending
      // flag or, in stop mode, an already asserted enabled pin, the raw pad path to the
      // wake controller sits in the clock gating outside this block
      wake_request <= irq_enable_bit &&
                      (event_flag || (stop_mode && any_asserted));
    end
  end

  // --------------------------------------------------------------------------
  // register read, data one cycle after the strobe; unmapped reads zero
  // --------------------------------------------------------------------------
  // reads have no side effect: the acknowledge bit is a strobe only and
  // always reads zero, and bits above the fields are tied low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      if (hit(addr, `KEY_STATUS_CONTROL_OFFSET)) begin
        rdata <= {4'h0, event_flag, 1'b0, irq_enable_bit, level_sense_select};
      end else if (hit(addr, `KEY_PIN_ENABLE_OFFSET)) begin
        rdata <= 8'(pin_enable_bits);
      end else if (hit(addr, `KEY_POLARITY_SELECT_OFFSET)) begin
        rdata <= 8'(polarity_bits);
      end else if (hit(addr, `KEY_IRQ_STATUS_OFFSET)) begin
        rdata <= {6'h00, evt_status};
      end else if (hit(addr, `KEY_IRQ_MASK_OFFSET)) begin
        rdata <= {6'h00, evt_mask};
      end else begin
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_irq_follows_flag: assert property (@(posedge core_clk) disable iff (rst)
    irq_request == $past(event_flag && irq_enable_bit))
    else $error("irq_request does not follow flag and enable");

  a_edge_sets_flag: assert property (@(posedge core_clk) disable iff (rst)
    edge_seen |=> event_flag)
    else $error("edge did not set the flag");

  a_level_holds_flag: assert property (@(posedge core_clk) disable iff (rst)
    (level_sense_select && any_asserted) |=> event_flag)
    else $error("flag cleared while a pin is asserted in level mode");

  a_ack_clears_flag: assert property (@(posedge core_clk) disable iff (rst)
    (ack_req && !set_flag && !(level_sense_select && any_asserted)) |=> !event_flag)
    else $error("acknowledge failed to clear the flag");

  a_no_spurious_set: assert property (@(posedge core_clk) disable iff (rst)
    (!event_flag && !set_flag) |=> !event_flag)
    else $error("flag set without an event");

  a_disabled_pins_idle: assert property (@(posedge core_clk) disable iff (rst)
    (pin_enable_bits == '0) |-> !set_flag)
    else $error("event with no pin enabled");

  a_no_double_edge: assert property (@(posedge core_clk) disable iff (rst)
    edge_seen |=> !edge_seen)
    else $error("second edge without return to idle");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
    $past(rd_stb && hit(addr, `KEY_STATUS_CONTROL_OFFSET)) |-> rdata[7:4] == 4'h0 &&
    rdata[`FLAG_ACKNOWLEDGE_BIT] == 1'b0)
    else $error("reserved or acknowledge bits read non-zero");

  a_edge_mode_only: assert property (@(posedge core_clk) disable iff (rst)
    !level_sense_select |-> set_flag == edge_seen)
    else $error("level detected in edge-only mode");

  // the two edge checks rebuild each edge from the raw samples and the
  // register bits, so a slip in asserted_of or in the masking shows up
  a_falling_edge_seen: assert property (@(posedge core_clk) disable iff (rst)
    ((arm_state == key_irq_pkg::ARM_READY) &&
     (|(pin_enable_bits & ~polarity_bits & prev_b & ~sync_b))) |-> edge_seen)
    else $error("enabled falling edge was not recognised");

  a_rising_edge_seen: assert property (@(posedge core_clk) disable iff (rst)
    ((arm_state == key_irq_pkg::ARM_READY) &&
     (|(pin_enable_bits & polarity_bits & ~prev_b & sync_b))) |-> edge_seen)
    else $error("enabled rising edge was not recognised");

  // a quiet pin set must re-arm on the very next edge
  a_rearm_when_idle: assert property (@(posedge core_clk) disable iff (rst)
    ((arm_state == key_irq_pkg::ARM_WAIT_IDLE) && !any_asserted) |=>
    (arm_state == key_irq_pkg::ARM_READY))
    else $error("detector did not re-arm with every pin idle");

  // a write without acknowledge leaves the flag alone, whatever bit 3 holds
  a_flag_write_ignored: assert property (@(posedge core_clk) disable iff (rst)
    (wr_sc && !wdata[`FLAG_ACKNOWLEDGE_BIT] && !set_flag) |=>
    (event_flag == $past(event_flag)))
    else $error("status write changed the flag");

  // the request stays low whenever the enable bit was low
  a_irq_gated_enable: assert property (@(posedge core_clk) disable iff (rst)
    !irq_enable_bit |=> !irq_request)
    else $error("request raised with the interrupt disabled");

  // wake follows a pending enabled flag and never rises with irq off
  a_wake_on_flag: assert property (@(posedge core_clk) disable iff (rst)
    (event_flag && irq_enable_bit) |=> wake_request)
    else $error("pending flag did not raise wake");

  a_wake_needs_enable: assert property (@(posedge core_clk) disable iff (rst)
    !irq_enable_bit |=> !wake_request)
    else $error("wake raised with the interrupt disabled");

  // the sticky status bits must catch every event the flag sees
  a_edge_sets_status: assert property (@(posedge core_clk) disable iff (rst)
    edge_seen |=> evt_status[`EVT_EDGE_BIT])
    else $error("edge did not set its status bit");

  a_level_sets_status: assert property (@(posedge core_clk) disable iff (rst)
    level_seen |=> evt_status[`EVT_LEVEL_BIT])
    else $error("level did not set its status bit");

  // the shared line is the masked status, one flop later
  a_irq_from_status: assert property (@(posedge core_clk) disable iff (rst)
    irq == $past(|(evt_status & evt_mask)))
    else $error("irq does not follow masked status");

  // read data stand for one cycle only and are zero otherwise
  a_read_idle_zero: assert property (@(posedge core_clk) disable iff (rst)
    !rd_stb |=> (rdata == 8'h00))
    else $error("read data not zero outside a read");

endmodule : keyboard_pin_interrupt
`default_nettype wire

//--- keyboard_pin_interrupt_tb_top.sv
// self-checking bench of the pin-change interrupt unit with a reference model
`timescale 1ns/1ps
`default_nettype none
`include "key_irq_map.svh"

module keyboard_pin_interrupt_tb_top;
  // ----------------------------------------------------------------------
  // design signals
  // ----------------------------------------------------------------------
  logic        core_clk, rst, wr_stb, rd_stb, stop_mode; // bus controls
  logic [15:0] addr;                                     // register address
  logic [7:0]  wdata, rdata, pins, d;                    // data and pin levels
  logic        irq_request, wake_request, irq;           // design outputs
  int          fails, cmp_count;                         // mismatch and compare counts
  // reference model state
  logic [7:0]  en_bits, pol_bits, pin_lvl, evt_bits, msk_bits;
  logic        flag, ie, lvl_mode, armed;
  logic [7:0]  p, q, s;                                  // random draws

  keyboard_pin_interrupt #(.PIN_COUNT(8)) uut (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .wake_input_pin(pins), .stop_mode(stop_mode),
    .irq_request(irq_request), .wake_request(wake_request), .irq(irq));
  key_switch_model sw (.core_clk(core_clk), .wake_input_pin(pins));

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk; // 250 MHz

  // ----------------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------------
  // enabled pins at their asserted level under the present polarity
  function automatic logic [7:0] act(input logic [7:0] v);
    return ~(v ^ pol_bits) & en_bits;
  endfunction : act

  // a held level keeps re-setting the flag; a quiet pin set re-arms edges
  function automatic void settle();
    if (lvl_mode && |act(pin_lvl)) begin
      flag = 1'b1;
      evt_bits[1] = 1'b1;
    end
    if (act(pin_lvl) == 8'h00) armed = 1'b1;
  endfunction : settle

  // ----------------------------------------------------------------------
  // bus and pin tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr <= a; wdata <= v; wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    case (a)
      `KEY_STATUS_CONTROL_OFFSET: begin
        lvl_mode = v[0];
        ie = v[1];
        if (v[2]) flag = 1'b0;
      end
      `KEY_PIN_ENABLE_OFFSET:     en_bits = v;
      `KEY_POLARITY_SELECT_OFFSET: pol_bits = v;
      `KEY_IRQ_STATUS_OFFSET:     evt_bits = evt_bits & ~v;
      `KEY_IRQ_MASK_OFFSET:       msk_bits = v;
      default: ; // unmapped writes change nothing
    endcase
    settle();
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge core_clk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic check_all();
    logic [7:0] v;
    rd(`KEY_STATUS_CONTROL_OFFSET, v);
    chk("sc", v, {4'h0, flag, 1'b0, ie, lvl_mode});
    rd(`KEY_PIN_ENABLE_OFFSET, v);
    chk("pe", v, en_bits);
    rd(`KEY_POLARITY_SELECT_OFFSET, v);
    chk("pol", v, pol_bits);
    rd(`KEY_IRQ_STATUS_OFFSET, v);
    chk("evt", v, evt_bits);
    chk("irq_request", {7'h0, irq_request}, {7'h0, flag & ie});
    chk("wake", {7'h0, wake_request}, {7'h0, ie & (flag | (stop_mode & |act(pin_lvl)))});
    chk("irq", {7'h0, irq}, {7'h0, |(evt_bits & msk_bits)});
    rd(`KEY_IRQ_MASK_OFFSET, v);
    chk("mask", v, {6'h00, msk_bits[1:0]});
  endtask : check_all

  // move the pins, let the two-stage sampler and flag settle, then compare
  task automatic step(input logic [7:0] v);
    logic [7:0] ao, an;
    logic       e;
    ao = act(pin_lvl);
    an = act(v);
    e = armed && |(an & ~ao);
    armed = (an == 8'h00) || (armed && !e);
    if (e) begin
      flag = 1'b1;
      evt_bits[0] = 1'b1;
    end
    pin_lvl = v;
    settle();
    sw.drive(v);
    repeat (6) @(posedge core_clk);
    check_all();
  endtask : step

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------------
  // about 3200 cycles are expected; the 60000-cycle limit, some nineteen times that, means a hang
  initial begin
    #240000;
    fails++;
    finish_test();
  end

  initial begin
    rst = 1'b1; addr = 16'h0000; wdata = 8'h00; wr_stb = 1'b0; rd_stb = 1'b0;
    stop_mode = 1'b0; en_bits = 8'h00; pol_bits = 8'h00; pin_lvl = 8'hFF;
    evt_bits = 8'h00; msk_bits = 8'h00; flag = 1'b0; ie = 1'b0; lvl_mode = 1'b0;
    armed = 1'b1; fails = 0; cmp_count = 0;
    void'($urandom(78029));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    check_all();
    rd(16'h0000, d);
    chk("unmapped", d, 8'h00);
    $display("test reset done");
    // safe bring-up: irq off, polarity, pins, acknowledge, irq on
    step(8'hF0);
    wr(`KEY_STATUS_CONTROL_OFFSET, 8'h00);
    wr(`KEY_POLARITY_SELECT_OFFSET, 8'h0F);
    wr(`KEY_PIN_ENABLE_OFFSET, 8'h7F);
    wr(`KEY_STATUS_CONTROL_OFFSET, 8'h04);
    wr(`KEY_STATUS_CONTROL_OFFSET, 8'h02);
    wr(`KEY_IRQ_MASK_OFFSET, 8'h03);
    step(8'hF1);                           // rising edge on pin 0
    wr(`KEY_STATUS_CONTROL_OFFSET, 8'hF2); // flag and reserved bits ignore writes
    check_all();
    wr(`KEY_STATUS_CONTROL_OFFSET, 8'h06);
    step(8'hF3);                           // second pin while first held: no edge
    step(8'hF0);
    step(8'hE0);                           // falling edge on pin 4
    wr(`KEY_IRQ_STATUS_OFFSET, 8'h01);
    wr(`KEY_STATUS_CONTROL_OFFSET, 8'h06);
    step(8'h60);                           // disabled pin 7 moves alone
    $display("test edge done");
    wr(`KEY_STATUS_CONTROL_OFFSET, 8'h03); // level mode with pin 4 still low
    wr(`KEY_STATUS_CONTROL_OFFSET, 8'h07);
    check_all();
    @(posedge core_clk);
    stop_mode <= 1'b1;
    check_all();
    step(8'hF0);
    wr(`KEY_STATUS_CONTROL_OFFSET, 8'h07);
    wr(16'h1234, 8'hFF);
    check_all();
    $display("test level done");
    for (int r = 0; r < 30; r++) begin
      p = 8'($urandom);
      q = 8'($urandom);
      s = 8'($urandom);
      step(~p);
      wr(`KEY_POLARITY_SELECT_OFFSET, p);
      wr(`KEY_PIN_ENABLE_OFFSET, q);
      wr(`KEY_IRQ_MASK_OFFSET, s);
      wr(`KEY_STATUS_CONTROL_OFFSET, {6'h00, s[7:6]});
      wr(`KEY_STATUS_CONTROL_OFFSET, {5'h00, 1'b1, s[7:6]});
      wr(`KEY_IRQ_STATUS_OFFSET, 8'hFF);
      @(posedge core_clk);
      stop_mode <= s[5];
      repeat (4) step(8'($urandom));
    end
    $display("test random done");
    // second reset in mid-run: registers back to zero, pins left where they are
    @(posedge core_clk);
    rst <= 1'b1;
    stop_mode <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    en_bits = 8'h00; pol_bits = 8'h00; evt_bits = 8'h00; msk_bits = 8'h00;
    flag = 1'b0; ie = 1'b0; lvl_mode = 1'b0; armed = 1'b1;
    check_all();
    $display("test midreset done");
    finish_test();
  end
endmodule : keyboard_pin_interrupt_tb_top

`default_nettype wire
